/* File: logic/ocb_clock_block.sv */
// oscillator and clock block: apb registers, start-up sequencing and ratio engine
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/100ps
module ocb_clock_block (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire ocb_pkg::ocb_addr_t    paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire ocb_pkg::ocb_osc_mode_t osc_mode_cfg,
    input  wire logic                  default_source_cfg_bit,
    input  wire logic                  fail_safe_en,
    input  wire logic                  watchdog_en,
    input  wire logic                  two_speed_en,
    input  wire logic                  sleep_req,
    input  wire logic                  clock_in_pin,
    input  wire logic                  secondary_clk_pin,
    output logic                       feedback_enable,
    output logic                       clock_out_pin_o,
    output logic                       clock_out_pin_oe_n,
    output logic                       internal_slow_osc,
    output logic [2:0]                 sys_clk_edges,
    output logic [1:0]                 active_source,
    output logic                       osc_ready
);
    import ocb_pkg::*;

    ocb_state_t    state_reg;
    ocb_state_t    state_next;
    logic [3:0]    cfg_cnt_reg;
    logic [10:0]   ost_cnt_reg;
    ocb_osc_mode_t mode_reg;
    logic          dflt_reg;
    ocb_pll_ctrl_t pll_block_control_reg;
    logic [1:0]    src_reg;
    logic          pready_reg;
    logic          pslverr_reg;
    logic [31:0]   prdata_reg;
    logic [9:0]    intosc_cnt_reg;
    logic          intosc_reg;
    ocb_ratio_t    cur_ratio_reg;
    logic [3:0]    acc_reg;
    logic [2:0]    edges_reg;
    logic [1:0]    source_reg;
    logic          feedback_reg;
    logic          oe_n_reg;
    logic          ready_reg;
    logic          prim_rise;
    logic          sec_rise;
    logic          is_ext;
    logic          mult_avail;
    logic          cfg_ext;
    logic [1:0]    src_now;
    logic          intosc_run;
    logic          intosc_rise;
    logic          eff_mult;
    logic          pre_on;
    logic [3:0]    pre_div;
    logic [3:0]    post_div;
    ocb_ratio_t    pend_ratio;
    logic          prim_edge_active;
    ocb_div_t      div_res;
    logic          mapped;
    logic          wr_commit;
    logic [31:0]   rd_data;
    logic [7:0]    status_val;

    // whole sys edges per primary edge and leftover phase
    function automatic ocb_div_t ocb_divide(input logic [3:0] sum, input logic [3:0] den);
        ocb_div_t r;
        r.cnt = 3'h0;
        r.rem = sum;
        for (int k = 0; k < 5; k++) begin
            if (r.rem >= den) begin
                r.rem = r.rem - den;
                r.cnt = r.cnt + 3'h1;
            end
        end
        return r;
    endfunction

    // pin inputs pass two flip-flops first
    ocb_sync_edge u_prim_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pin_in  (clock_in_pin),
        .level   (),
        .rise    (prim_rise)
    );

    ocb_sync_edge u_sec_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pin_in  (secondary_clk_pin),
        .level   (),
        .rise    (sec_rise)
    );

    // mode predicates
    assign is_ext     = (mode_reg == EXT_CLOCK_MODE) || (mode_reg == EXT_CLOCK_MULT_MODE);
    assign mult_avail = (mode_reg == CRYSTAL_MULT_MODE) || (mode_reg == EXT_CLOCK_MULT_MODE);
    assign cfg_ext    = (osc_mode_cfg == EXT_CLOCK_MODE) || (osc_mode_cfg == EXT_CLOCK_MULT_MODE);

    // start-up sequencing
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_CFG: begin
                if (cfg_cnt_reg == CFG_CYCLES - 4'h1) begin
                    state_next = cfg_ext ? ST_RUN : ST_START;
                end
            end
            ST_START: begin
                if (prim_rise && (ost_cnt_reg == OST_EDGES - 11'h1)) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (sleep_req) begin
                    state_next = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (!sleep_req) begin
                    state_next = is_ext ? ST_RUN : ST_START;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_CFG;
        end else begin
            state_reg <= state_next;
        end
    end

    // configuration cycle length and strap capture at its end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_cnt_reg <= 4'h0;
            mode_reg    <= CRYSTAL_DRIVE_MODE;
            dflt_reg    <= 1'b1;
        end else if (state_reg == ST_CFG) begin
            cfg_cnt_reg <= cfg_cnt_reg + 4'h1;
            if (cfg_cnt_reg == CFG_CYCLES - 4'h1) begin
                mode_reg <= osc_mode_cfg;
                dflt_reg <= default_source_cfg_bit;
            end
        end
    end

    // crystal start-up wait counts primary edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ost_cnt_reg <= 11'h0;
        end else if (state_reg != ST_START) begin
            ost_cnt_reg <= 11'h0;
        end else if (prim_rise) begin
            ost_cnt_reg <= ost_cnt_reg + 11'h1;
        end
    end

    // source decode; configuration always runs on the internal oscillator
    always_comb begin
        src_now = SRC_INTERNAL;
        if (state_reg != ST_CFG) begin
            unique case (src_reg)
                SRC_SEL_DEFAULT: src_now = dflt_reg ? SRC_PRIMARY : SRC_INTERNAL;
                SRC_SECONDARY:   src_now = SRC_SECONDARY;
                SRC_PRIMARY:     src_now = SRC_PRIMARY;
                SRC_INTERNAL:    src_now = SRC_INTERNAL;
            endcase
        end
    end

    // internal oscillator enable and divider
    assign intosc_run  = (state_reg == ST_CFG) || ((src_now == SRC_INTERNAL) && (state_reg != ST_SLEEP)) ||
                         fail_safe_en || watchdog_en || two_speed_en;
    assign intosc_rise = intosc_run && !intosc_reg && (intosc_cnt_reg == INTOSC_HALF - 10'h1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            intosc_cnt_reg <= 10'h0;
            intosc_reg     <= 1'b0;
        end else if (!intosc_run) begin
            intosc_cnt_reg <= 10'h0;
            intosc_reg     <= 1'b0;
        end else if (intosc_cnt_reg == INTOSC_HALF - 10'h1) begin
            intosc_cnt_reg <= 10'h0;
            intosc_reg     <= ~intosc_reg;
        end else begin
            intosc_cnt_reg <= intosc_cnt_reg + 10'h1;
        end
    end

    // ratio chosen by the control register
    assign eff_mult       = pll_block_control_reg.mult_enable && mult_avail;
    assign pre_on         = eff_mult || pll_block_control_reg.post_div_enable;
    assign pre_div        = pre_on ? (pll_block_control_reg.pre_div_ratio_select ? DIV2 : DIV3) : DIV1;
    assign post_div       = pll_block_control_reg.post_div_enable ?
                            (pll_block_control_reg.post_div_ratio_select ? DIV2 : DIV3) : DIV1;
    assign pend_ratio.num = eff_mult ? MULT_FACTOR : DIV1;
    assign pend_ratio.den = 4'(pre_div * post_div);

    // phase accumulator; primary edges scaled by num over den
    assign prim_edge_active = prim_rise && (state_reg == ST_RUN);
    always_comb begin
        div_res.cnt = 3'h0;
        div_res.rem = acc_reg;
        if (prim_edge_active) begin
            div_res = ocb_divide(acc_reg + cur_ratio_reg.num, cur_ratio_reg.den);
        end
    end

    // new ratio is taken only at a phase boundary so no pulse is cut short
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_reg       <= 4'h0;
            cur_ratio_reg <= RATIO_RESET;
        end else begin
            acc_reg <= div_res.rem;
            if (div_res.rem == 4'h0) begin
                cur_ratio_reg <= pend_ratio;
            end
        end
    end

    // system clock edges per pclk cycle from the active source
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edges_reg  <= 3'h0;
            source_reg <= SRC_INTERNAL;
        end else begin
            source_reg <= src_now;
            if (state_reg == ST_SLEEP) begin
                edges_reg <= 3'h0;
            end else if (src_now == SRC_PRIMARY) begin
                edges_reg <= div_res.cnt;
            end else if (src_now == SRC_SECONDARY) begin
                edges_reg <= {2'h0, sec_rise};
            end else begin
                edges_reg <= {2'h0, intosc_rise};
            end
        end
    end

    // pin and feedback controls
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            feedback_reg <= 1'b0;
            oe_n_reg     <= 1'b1;
            ready_reg    <= 1'b0;
        end else begin
            feedback_reg <= (state_reg != ST_CFG) && !is_ext;
            oe_n_reg     <= !((state_reg != ST_CFG) && (mode_reg == EXT_CLOCK_MODE));
            ready_reg    <= (state_next == ST_RUN);
        end
    end

    ocb_quarter_div u_quarter (
        .pclk    (pclk),
        .presetn (presetn),
        .edge_in (prim_rise),
        .enable  ((state_reg == ST_RUN) && (mode_reg == EXT_CLOCK_MODE)),
        .div_out (clock_out_pin_o)
    );

    // apb decode and read mux
    assign mapped    = (paddr == PLL_CTRL_OFF) || (paddr == SRC_CTRL_OFF) || (paddr == STATUS_OFF);
    assign wr_commit = psel && penable && pready_reg && pwrite && mapped;
    always_comb begin
        status_val                          = 8'h00;
        status_val[ST_READY_BIT]            = ready_reg;
        status_val[ST_INTOSC_BIT]           = intosc_run;
        status_val[ST_FEEDBACK_BIT]         = feedback_reg;
        status_val[ST_MULT_AVAIL_BIT]       = mult_avail;
        status_val[ST_SOURCE_LSB +: 2]      = source_reg;
        rd_data = 32'h0;
        if (paddr == PLL_CTRL_OFF) begin
            rd_data[CTRL_FIELD_LSB +: 4] = pll_block_control_reg;
        end else if (paddr == SRC_CTRL_OFF) begin
            rd_data[1:0] = src_reg;
        end else if (paddr == STATUS_OFF) begin
            rd_data[7:0] = status_val;
        end
    end

    // one wait state, answer registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0;
        end else if (psel && penable && !pready_reg) begin
            pready_reg  <= 1'b1;
            pslverr_reg <= !mapped;
            prdata_reg  <= pwrite ? 32'h0 : rd_data;
        end else begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end
    end

    // register writes take effect at the completing edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_block_control_reg <= PLL_CTRL_RESET;
            src_reg               <= SRC_CTRL_RESET;
        end else if (wr_commit) begin
            if (paddr == PLL_CTRL_OFF) begin
                pll_block_control_reg             <= pwdata[CTRL_FIELD_LSB +: 4];
                pll_block_control_reg.mult_enable <= pwdata[CTRL_FIELD_LSB + 2] && mult_avail;
            end else if (paddr == SRC_CTRL_OFF) begin
                src_reg <= pwdata[1:0];
            end
        end
    end

    assign prdata             = prdata_reg;
    assign pready             = pready_reg;
    assign pslverr            = pslverr_reg;
    assign feedback_enable    = feedback_reg;
    assign clock_out_pin_oe_n = oe_n_reg;
    assign internal_slow_osc  = intosc_reg;
    assign sys_clk_edges      = edges_reg;
    assign active_source      = source_reg;
    assign osc_ready          = ready_reg;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    ext_pin_drive_a: assert property ((state_reg == ST_RUN) && (mode_reg == EXT_CLOCK_MODE) |=>
                                      !clock_out_pin_oe_n)
        else $error("second pin not driven in external clock mode");
    ext_no_wait_a: assert property ((state_reg == ST_SLEEP) && !sleep_req && is_ext |=> state_reg == ST_RUN)
        else $error("external clock mode waited for start-up");
    feedback_mode_a: assert property ((state_reg == ST_RUN) [*2] |-> feedback_enable == !is_ext)
        else $error("feedback circuit state wrong for mode");
    cfg_osc_run_a: assert property (state_reg == ST_CFG |=>
                                    intosc_cnt_reg == $past(intosc_cnt_reg) + 10'h1)
        else $error("internal oscillator idle during configuration");
    feature_osc_a: assert property ((watchdog_en || fail_safe_en || two_speed_en) |=>
                                    intosc_cnt_reg != $past(intosc_cnt_reg))
        else $error("internal oscillator stopped while a feature needs it");
    default_src_a: assert property ((state_reg == ST_RUN) && (src_reg == SRC_SEL_DEFAULT) |=>
                                    active_source == ($past(dflt_reg) ? SRC_PRIMARY : SRC_INTERNAL))
        else $error("default source decode wrong");
    mult_read_zero_a: assert property (!mult_avail |-> !pll_block_control_reg.mult_enable)
        else $error("multiplier bit set outside multiplier modes");
    pre_bypass_a: assert property (!eff_mult && !pll_block_control_reg.post_div_enable |->
                                   pend_ratio == RATIO_RESET)
        else $error("prescaler active with multiplier and postscaler off");
    ratio_div4_a: assert property (eff_mult && pll_block_control_reg.post_div_enable &&
                                   pll_block_control_reg.post_div_ratio_select &&
                                   pll_block_control_reg.pre_div_ratio_select |-> pend_ratio.den == 4'h4)
        else $error("divide two by two ratio wrong");
    phase_range_a: assert property (acc_reg < cur_ratio_reg.den)
        else $error("phase accumulator out of range");
    ratio_boundary_a: assert property ($changed(cur_ratio_reg) |-> $past(div_res.rem) == 4'h0)
        else $error("ratio changed mid period");

    cover_ext_run: cover property ((state_reg == ST_RUN) && (mode_reg == EXT_CLOCK_MODE) && !clock_out_pin_oe_n);
    cover_mult_ratio: cover property (cur_ratio_reg.num == MULT_FACTOR && sys_clk_edges > 3'h1);
    cover_sleep_wake: cover property ((state_reg == ST_SLEEP) ##1 (state_reg == ST_START));
endmodule

/* File: logic/ocb_pkg.sv */
// constants, types and register layout shared by the oscillator and clock block
package ocb_pkg;
    typedef logic [11:0] ocb_addr_t;

    typedef enum logic [1:0] {
        CRYSTAL_DRIVE_MODE  = 2'b00,
        CRYSTAL_MULT_MODE   = 2'b01,
        EXT_CLOCK_MODE      = 2'b10,
        EXT_CLOCK_MULT_MODE = 2'b11
    } ocb_osc_mode_t;

    typedef enum logic [3:0] {
        ST_CFG   = 4'b0001,
        ST_START = 4'b0010,
        ST_RUN   = 4'b0100,
        ST_SLEEP = 4'b1000
    } ocb_state_t;

    typedef struct packed {
        logic post_div_ratio_select;
        logic mult_enable;
        logic post_div_enable;
        logic pre_div_ratio_select;
    } ocb_pll_ctrl_t;

    typedef struct packed {
        logic [3:0] num;
        logic [3:0] den;
    } ocb_ratio_t;

    typedef struct packed {
        logic [2:0] cnt;
        logic [3:0] rem;
    } ocb_div_t;

    // register byte addresses
    localparam ocb_addr_t     PLL_CTRL_OFF      = 12'h000;
    localparam ocb_addr_t     SRC_CTRL_OFF      = 12'h004;
    localparam ocb_addr_t     STATUS_OFF        = 12'h008;
    // control field positions
    localparam int            CTRL_FIELD_LSB    = 4;
    localparam ocb_pll_ctrl_t PLL_CTRL_RESET    = 4'h0;
    localparam logic [1:0]    SRC_CTRL_RESET    = 2'h0;
    // status field positions
    localparam int            ST_READY_BIT      = 0;
    localparam int            ST_INTOSC_BIT     = 1;
    localparam int            ST_FEEDBACK_BIT   = 2;
    localparam int            ST_MULT_AVAIL_BIT = 3;
    localparam int            ST_SOURCE_LSB     = 4;
    // source select codes
    localparam logic [1:0]    SRC_SEL_DEFAULT   = 2'b00;
    localparam logic [1:0]    SRC_SECONDARY     = 2'b01;
    localparam logic [1:0]    SRC_PRIMARY       = 2'b10;
    localparam logic [1:0]    SRC_INTERNAL      = 2'b11;
    // ratios
    localparam logic [3:0]    MULT_FACTOR       = 4'h5;
    localparam logic [3:0]    DIV1              = 4'h1;
    localparam logic [3:0]    DIV2              = 4'h2;
    localparam logic [3:0]    DIV3              = 4'h3;
    localparam ocb_ratio_t    RATIO_RESET       = 8'h11;
    localparam logic [1:0]    EXT_OUT_HALF      = 2'h2;
    // timing
    localparam int            CLK_HZ            = 50_000_000;
    localparam int            INTOSC_HZ         = 31_000;
    localparam logic [9:0]    INTOSC_HALF       = 10'(CLK_HZ / INTOSC_HZ / 2);
    localparam logic [3:0]    CFG_CYCLES        = 4'h8;
    localparam logic [10:0]   OST_EDGES         = 11'h400;
endpackage

/* File: logic/ocb_quarter_div.sv */
// divides a stream of clock edges by four into a square wave
`timescale 1ns/100ps
module ocb_quarter_div (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic edge_in,
    input  wire logic enable,
    output logic      div_out
);
    import ocb_pkg::*;

    logic [1:0] cnt_reg;

    // toggle every second input edge; parked low while disabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 2'h0;
            div_out <= 1'b0;
        end else if (!enable) begin
            cnt_reg <= 2'h0;
            div_out <= 1'b0;
        end else if (edge_in) begin
            if (cnt_reg == EXT_OUT_HALF - 2'h1) begin
                cnt_reg <= 2'h0;
                div_out <= ~div_out;
            end else begin
                cnt_reg <= cnt_reg + 2'h1;
            end
        end
    end
endmodule

/* File: logic/ocb_sync_edge.sv */
// two-stage pin synchroniser with a rising edge pulse
`timescale 1ns/100ps
module ocb_sync_edge (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pin_in,
    output logic      level,
    output logic      rise
);
    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    // first stage feeds only the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end else begin
            meta_reg <= pin_in;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    // edge is taken between the settled stages
    assign level = sync_reg;
    assign rise  = sync_reg & ~last_reg;
endmodule

/* File: verification/ocb_clock_block_tb.sv */
// self-checking bench for the oscillator and clock block
`timescale 1ns/100ps
`define CHK(g, e) check(32'(g), 32'(e))
module ocb_clock_block_tb;
    import ocb_pkg::*;
    logic          pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, run = 1'b1;
    logic          default_source_cfg_bit = 1'b1, watchdog_en = 1'b0, sleep_req = 1'b0;
    logic          fail_safe_en = 1'b0, two_speed_en = 1'b0;
    ocb_addr_t     paddr = 12'h000;
    ocb_osc_mode_t osc_mode_cfg = EXT_CLOCK_MODE;
    logic [31:0]   pwdata = 32'h0, prdata, rd, sum, outs;
    logic          pready, pslverr, er, feedback_enable, clock_out_pin_o, clock_out_pin_oe_n;
    logic          internal_slow_osc, osc_ready, clock_in_pin;
    logic [2:0]    sys_clk_edges;
    logic [1:0]    active_source;
    int            mismatches = 0, comparisons = 0, n;
    // control settings and expected system edges per 360 primary edges; reserved x101 never used
    logic [7:0]    ctrl_tab [10] = '{8'hf0, 8'h70, 8'h40, 8'he0, 8'h60, 8'h00, 8'hb0, 8'h30, 8'ha0, 8'h20};
    logic [31:0]   rate_tab [10] = '{32'h1c2, 32'h12c, 32'h258, 32'h12c, 32'hc8, 32'h168, 32'h5a, 32'h3c,
                                     32'h3c, 32'h28};

    ocb_clock_block ocb_clock_block_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .osc_mode_cfg, .default_source_cfg_bit, .fail_safe_en, .watchdog_en,
        .two_speed_en, .sleep_req, .clock_in_pin, .secondary_clk_pin(clock_in_pin), .feedback_enable,
        .clock_out_pin_o, .clock_out_pin_oe_n, .internal_slow_osc, .sys_clk_edges, .active_source, .osc_ready);
    ocb_primary_src ocb_primary_src_i (.run, .clock_in_pin);

    // 50 mhz bench clock
    initial begin
        forever #10 pclk = ~pclk;
    end

    task automatic check(input logic [31:0] g, e);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask

    task automatic near(input logic [31:0] g, e);
        `CHK(g + 6 >= e && g <= e + 6, 1'b1);
    endtask

    task automatic results;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // straps set, reset held five cycles, internal source checked before release
    task automatic boot(input ocb_osc_mode_t m, input logic d);
        osc_mode_cfg <= m;
        default_source_cfg_bit <= d;
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        `CHK(active_source, SRC_INTERNAL);
        presetn <= 1'b1;
    endtask

    // one apb transfer: setup, access held until pready is sampled high
    task automatic xfer(input logic w, input ocb_addr_t a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        `CHK(n, 2);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // sums system edges and divided output rises over 360 primary periods
    task automatic measure;
        logic last;
        sum = 32'h0;
        outs = 32'h0;
        last = clock_out_pin_o;
        repeat (720) begin
            @(posedge pclk);
            sum += 32'(sys_clk_edges);
            outs += 32'(clock_out_pin_o & ~last);
            last = clock_out_pin_o;
        end
    endtask

    task automatic wait_ready;
        n = 0;
        while (osc_ready !== 1'b1 && n < 3000) begin
            @(posedge pclk);
            n++;
        end
    endtask

    // main sequence
    initial begin
        boot(EXT_CLOCK_MODE, 1'b1);
        repeat (20) @(posedge pclk);
        `CHK({osc_ready, feedback_enable, clock_out_pin_oe_n}, 3'b100);
        xfer(1'b0, PLL_CTRL_OFF, 32'h0);
        `CHK(rd, 32'h0);
        measure;
        near(sum, 32'h168);
        near(outs, 32'h5a);
        xfer(1'b1, PLL_CTRL_OFF, 32'hff);
        xfer(1'b0, PLL_CTRL_OFF, 32'h0);
        `CHK(rd, 32'hb0);
        xfer(1'b0, 12'h00c, 32'h0);
        `CHK(er, 1'b1);
        `CHK(rd, 32'h0);
        sleep_req <= 1'b1;
        run <= 1'b0;
        repeat (20) @(posedge pclk);
        sleep_req <= 1'b0;
        run <= 1'b1;
        repeat (12) @(posedge pclk);
        `CHK(osc_ready, 1'b1);
        boot(EXT_CLOCK_MULT_MODE, 1'b1);
        repeat (20) @(posedge pclk);
        for (int i = 0; i < 10; i++) begin
            xfer(1'b1, PLL_CTRL_OFF, 32'(ctrl_tab[i]));
            xfer(1'b0, PLL_CTRL_OFF, 32'h0);
            `CHK(rd, ctrl_tab[i]);
            repeat (40) @(posedge pclk);
            measure;
            near(sum, rate_tab[i]);
        end
        boot(CRYSTAL_DRIVE_MODE, 1'b0);
        repeat (1000) @(posedge pclk);
        `CHK(osc_ready, 1'b0);
        wait_ready;
        `CHK({osc_ready, feedback_enable, active_source}, {2'b11, SRC_INTERNAL});
        xfer(1'b1, PLL_CTRL_OFF, 32'h40);
        xfer(1'b0, PLL_CTRL_OFF, 32'h0);
        `CHK(rd, 32'h0);
        xfer(1'b1, SRC_CTRL_OFF, 32'(SRC_PRIMARY));
        repeat (10) @(posedge pclk);
        xfer(1'b0, STATUS_OFF, 32'h0);
        `CHK({rd[ST_INTOSC_BIT], active_source}, {1'b0, SRC_PRIMARY});
        // each feature alone must keep the internal oscillator toggling
        for (int f = 0; f < 3; f++) begin
            {two_speed_en, fail_safe_en, watchdog_en} <= 3'(1 << f);
            repeat (2) @(posedge pclk);
            rd = 32'(internal_slow_osc);
            n = 0;
            while (internal_slow_osc === rd[0] && n < 1700) begin
                @(posedge pclk);
                n++;
            end
            `CHK(n < 1700, 1'b1);
        end
        {two_speed_en, fail_safe_en, watchdog_en} <= 3'h0;
        xfer(1'b1, SRC_CTRL_OFF, 32'(SRC_SECONDARY));
        measure;
        near(sum, 32'h168);
        xfer(1'b1, SRC_CTRL_OFF, 32'(SRC_INTERNAL));
        xfer(1'b0, STATUS_OFF, 32'h0);
        `CHK({rd[ST_INTOSC_BIT], active_source}, {1'b1, SRC_INTERNAL});
        boot(CRYSTAL_DRIVE_MODE, 1'b1);
        wait_ready;
        `CHK(active_source, SRC_PRIMARY);
        results;
    end

    // watchdog against a hang
    initial begin
        #1_000_000;
        mismatches++;
        results;
    end
endmodule

/* File: verification/ocb_primary_src.sv */
// primary clock source model driving the first oscillator pin
`timescale 1ns/100ps
module ocb_primary_src #(
    parameter int HALF_NS = 20
) (
    input  wire logic run,
    output logic      clock_in_pin
);
    // 25 mhz square wave, phase offset from the bench clock, held low while stopped
    initial begin
        clock_in_pin = 1'b0;
        #3;
        forever begin
            #(HALF_NS);
            clock_in_pin = run ? ~clock_in_pin : 1'b0;
        end
    end
endmodule
